/* include/cbdl_cfg.svh */
// Timing, count and register map constants for the clock bank control
`ifndef CBDL_CFG_SVH
`define CBDL_CFG_SVH

// Clock and phase limit
`define CBDL_CLK_PS        8000
`define CBDL_PHASE_LIM_PS  250
`define CBDL_PHASE_LIM_CYC \
   (((`CBDL_PHASE_LIM_PS) / (`CBDL_CLK_PS)) < 1 ? 1 : \
    ((`CBDL_PHASE_LIM_PS) / (`CBDL_CLK_PS)))

// Lock detector run lengths
`define CBDL_ERR_RUN       4
`define CBDL_GOOD_RUN      32
`define CBDL_AGE_MAX       4'hF

// Factory test reset
`define CBDL_TRST_EDGES    5

// Watchdog
`define CBDL_WD_DIV_LAST   4'hF
`define CBDL_WD_TO_RST     8'h10
`define CBDL_WD_MAX        8'hFF

// Register indices (word address)
`define CBDL_REG_CTRL      1'h0
`define CBDL_REG_STAT      1'h1
`endif

/* include/cbdl_pkg.sv */
// Types shared by the clock bank control logic
package cbdl_pkg;
   typedef enum logic [1:0]
   {
      CBDL_MODE_LOW  = 2'h0,
      CBDL_MODE_MID  = 2'h1,
      CBDL_MODE_HIGH = 2'h2
   } cbdl_mode_t;

   typedef enum logic [1:0]
   {
      PK_RUN  = 2'h0,
      PK_WAIT = 2'h1,
      PK_PARK = 2'h2
   } cbdl_park_t;

   typedef enum logic [1:0]
   {
      TR_IDLE  = 2'h0,
      TR_COUNT = 2'h1,
      TR_HOLD  = 2'h2
   } cbdl_trst_t;

   typedef struct packed
   {
      logic        read;
      logic        write;
      logic [0:0]  address;
      logic [31:0] writedata;
   } cbdl_avs_req_t;

   typedef struct packed
   {
      logic [24:0] zero;
      cbdl_park_t  park_b;
      cbdl_park_t  park_a;
      logic        hold;
      logic        test;
      logic        lock;
   } cbdl_stat_t;
endpackage

/* hw/cbdl_top.sv */
// Clock bank disable, lock detect and factory test control
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`include "cbdl_cfg.svh"
module cbdl_top
(
   // System
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // Static configuration pins
   input  wire logic [1:0]              mode_level,
   input  wire logic [1:0]              bank_off_inputs,
   // Clock pins
   input  wire logic                    ref_in,
   input  wire logic                    feedback_in,
   input  wire logic                    pll_clk_in,
   // Bank clock pins
   output logic [3:0]                   bank_a_outputs,
   output logic [3:0]                   bank_a_oe,
   output logic [5:0]                   bank_b_outputs,
   output logic [5:0]                   bank_b_oe,
   // Lock indicator
   output logic                         lock_out,
   // Register bus
   input  wire cbdl_pkg::cbdl_avs_req_t avs_req,
   output logic [31:0]                  avs_readdata,
   output logic                         avs_waitrequest
);
   import cbdl_pkg::*;

   // Every check here runs on the system clock, quiet in reset
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   localparam int NPIN = 7;
   localparam logic [3:0] LIM_CYC = 4'(`CBDL_PHASE_LIM_CYC);
   localparam logic [2:0] ERR_LAST = 3'(`CBDL_ERR_RUN - 1);
   localparam logic [5:0] GOOD_LAST = 6'(`CBDL_GOOD_RUN - 1);
   localparam logic [2:0] TRST_LAST = 3'(`CBDL_TRST_EDGES - 1);

   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] pin_f;
   logic [1:0]      mode_f;
   logic [1:0]      off_f;
   logic            ref_f;
   logic            fb_f;
   logic            pll_f;
   logic            test;
   logic            fb_int;
   logic            src;
   logic            ref_d_r;
   logic            fb_d_r;
   logic            ref_rise;
   logic            fb_rise;
   logic            bank_b_off_input;
   logic            sm_rst;
   cbdl_trst_t      tr_r;
   logic [2:0]      tr_cnt_r;
   logic [3:0]      age_r;
   logic            pend_r;
   logic [3:0]      pend_cnt_r;
   logic            ph_ok_r;
   logic            ph_err_r;
   logic            lock_r;
   logic [2:0]      err_cnt_r;
   logic [5:0]      good_cnt_r;
   logic [3:0]      wd_div_r;
   logic [7:0]      wd_cnt_r;
   logic [7:0]      wd_to_r;
   logic            wd_exp;
   logic [1:0]      q_v;
   logic [1:0]      oe_v;
   cbdl_park_t      pk_v [2];
   logic            wait_r;
   logic [31:0]     rdata_r;
   cbdl_stat_t      stat;

   // Pin order: mode, disables, feedback, reference, PLL clock
   assign pin_raw = {pll_clk_in, ref_in, feedback_in,
                     bank_off_inputs, mode_level};

   // Three-stage filter; a change counts once stages two and three agree
   genvar p;
   generate
      for (p = 0; p < NPIN; p++)
      begin : g_sync
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic f_r;
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               f_r  <= 1'b0;
            end
            else
            begin
               s1_r <= pin_raw[p];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r)
                  f_r <= s3_r;
            end
         end
         assign pin_f[p] = f_r;
      end
   endgenerate

   assign mode_f = pin_f[1:0];
   assign off_f  = pin_f[3:2];
   assign fb_f   = pin_f[4];
   assign ref_f  = pin_f[5];
   assign pll_f  = pin_f[6];
   assign bank_b_off_input = off_f[1];

   // Middle level, and the unused code, both mean factory test
   assign test = (mode_f != CBDL_MODE_LOW) &&
                 (mode_f != CBDL_MODE_HIGH);
   assign fb_int = fb_f & ~test;
   assign src = test ? ref_f : pll_f;

   // Edge detect on the filtered clocks
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ref_d_r <= 1'b0;
         fb_d_r  <= 1'b0;
      end
      else
      begin
         ref_d_r <= ref_f;
         fb_d_r  <= fb_int;
      end
   end
   assign ref_rise = ref_f & ~ref_d_r;
   assign fb_rise  = fb_int & ~fb_d_r;

   // Factory test reset sequence
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tr_r     <= TR_IDLE;
         tr_cnt_r <= 3'h0;
      end
      else
      begin
         case (tr_r)
            TR_IDLE:
            begin
               tr_cnt_r <= 3'h0;
               if (test && bank_b_off_input)
                  tr_r <= TR_COUNT;
            end
            TR_COUNT:
            begin
               if (!(test && bank_b_off_input))
                  tr_r <= TR_IDLE;
               else if (ref_rise)
               begin
                  tr_cnt_r <= tr_cnt_r + 3'h1;
                  if (tr_cnt_r == TRST_LAST)
                     tr_r <= TR_HOLD;
               end
            end
            TR_HOLD:
            begin
               if (!(test && bank_b_off_input))
                  tr_r <= TR_IDLE;
            end
            default:
               tr_r <= TR_IDLE;
         endcase
      end
   end
   assign sm_rst = (tr_r == TR_HOLD);

   // Phase check: a reference edge must lie within the limit of feedback
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         age_r      <= `CBDL_AGE_MAX;
         pend_r     <= 1'b0;
         pend_cnt_r <= 4'h0;
         ph_ok_r    <= 1'b0;
         ph_err_r   <= 1'b0;
      end
      else
      begin
         ph_ok_r  <= 1'b0;
         ph_err_r <= 1'b0;
         if (ref_rise)
            age_r <= 4'h0;
         else if (age_r != `CBDL_AGE_MAX)
            age_r <= age_r + 4'h1;
         if (sm_rst)
            pend_r <= 1'b0;
         else if (fb_rise)
         begin
            pend_cnt_r <= 4'h0;
            if (ref_rise || age_r < LIM_CYC)
               ph_ok_r <= 1'b1;
            else
               pend_r <= 1'b1;
         end
         else if (pend_r)
         begin
            pend_cnt_r <= pend_cnt_r + 4'h1;
            if (ref_rise)
            begin
               pend_r  <= 1'b0;
               ph_ok_r <= 1'b1;
            end
            else if (pend_cnt_r + 4'h1 == LIM_CYC)
            begin
               pend_r   <= 1'b0;
               ph_err_r <= 1'b1;
            end
         end
      end
   end

   // Watchdog on a divided reference, restarted by feedback
   assign wd_exp = lock_r && (wd_cnt_r >= wd_to_r);
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wd_div_r <= 4'h0;
         wd_cnt_r <= 8'h0;
      end
      else if (sm_rst || fb_rise)
      begin
         wd_div_r <= 4'h0;
         wd_cnt_r <= 8'h0;
      end
      else if (ref_rise)
      begin
         wd_div_r <= wd_div_r + 4'h1;
         if (wd_div_r == `CBDL_WD_DIV_LAST &&
             wd_cnt_r != `CBDL_WD_MAX)
            wd_cnt_r <= wd_cnt_r + 8'h1;
      end
   end

   // Lock state: error run drops it, clean run raises it
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lock_r     <= 1'b0;
         err_cnt_r  <= 3'h0;
         good_cnt_r <= 6'h0;
      end
      else if (sm_rst || wd_exp)
      begin
         lock_r     <= 1'b0;
         err_cnt_r  <= 3'h0;
         good_cnt_r <= 6'h0;
      end
      else if (ph_err_r)
      begin
         good_cnt_r <= 6'h0;
         err_cnt_r  <= 3'h0;
         if (lock_r && err_cnt_r == ERR_LAST)
            lock_r <= 1'b0;
         else if (lock_r)
            err_cnt_r <= err_cnt_r + 3'h1;
      end
      else if (ph_ok_r)
      begin
         err_cnt_r <= 3'h0;
         if (!lock_r)
         begin
            good_cnt_r <= good_cnt_r + 6'h1;
            if (good_cnt_r == GOOD_LAST)
            begin
               lock_r     <= 1'b1;
               good_cnt_r <= 6'h0;
            end
         end
      end
   end

   // Per-bank park logic; parking only in normal mode with mode low
   genvar b;
   generate
      for (b = 0; b < 2; b++)
      begin : g_bank
         cbdl_park_t pk_r;
         logic       q_r;
         logic       oe_r;
         logic       req;
         assign req = off_f[b] && !test &&
                      (mode_f == CBDL_MODE_LOW);
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               pk_r <= PK_RUN;
               q_r  <= 1'b0;
               oe_r <= 1'b1;
            end
            else if (sm_rst)
            begin
               pk_r <= PK_RUN;
               q_r  <= 1'b0;
               oe_r <= 1'b0;
            end
            else
            begin
               oe_r <= (tr_r == TR_IDLE);
               case (pk_r)
                  PK_RUN:
                  begin
                     q_r <= src;
                     if (req)
                        pk_r <= PK_WAIT;
                  end
                  PK_WAIT:
                  begin
                     q_r <= src;
                     if (!req)
                        pk_r <= PK_RUN;
                     else if (!src)
                        pk_r <= PK_PARK;
                  end
                  PK_PARK:
                  begin
                     q_r <= 1'b0;
                     if (!req && !src)
                        pk_r <= PK_RUN;
                  end
                  default:
                     pk_r <= PK_RUN;
               endcase
            end
         end
         assign q_v[b] = q_r;
         assign pk_v[b] = pk_r;
         // Float path bypasses the filter so it acts without an edge
         assign oe_v[b] = oe_r & ~(bank_off_inputs[b] &&
                          mode_level == CBDL_MODE_HIGH);

         property p_run_follow;
            (pk_r == PK_RUN && !sm_rst) |=> (q_r == $past(src));
         endproperty
         a_run_follow: assert property (p_run_follow)
            else $error("running bank does not follow source");
         property p_hiz_now;
            (bank_off_inputs[b] && mode_level == CBDL_MODE_HIGH)
               |-> !oe_v[b];
         endproperty
         a_hiz_now: assert property (p_hiz_now)
            else $error("bank not floated at once");
         property p_park;
            (pk_r == PK_WAIT && req && !src && !sm_rst)
               |=> (pk_r == PK_PARK) ##1 !q_r;
         endproperty
         a_park: assert property (p_park)
            else $error("bank did not park on low source");
         property p_park_low;
            (pk_r == PK_PARK && $past(pk_r) == PK_PARK) |-> !q_r;
         endproperty
         a_park_low: assert property (p_park_low)
            else $error("parked bank output not low");
         c_park: cover property (pk_r == PK_WAIT ##[1:40] pk_r == PK_PARK);
      end
   endgenerate

   // Bank pins: one flop per bank fans out to every output of it
   assign bank_a_outputs = {4{q_v[0]}};
   assign bank_a_oe      = {4{oe_v[0]}};
   assign bank_b_outputs = {6{q_v[1]}};
   assign bank_b_oe      = {6{oe_v[1]}};
   assign lock_out       = lock_r;

   // Status word
   always_comb
   begin
      stat        = '0;
      stat.lock   = lock_r;
      stat.test   = test;
      stat.hold   = sm_rst;
      stat.park_a = pk_v[0];
      stat.park_b = pk_v[1];
   end

   // Avalon slave: one wait cycle, then answer for exactly one cycle
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h0;
         wd_to_r <= `CBDL_WD_TO_RST;
      end
      else
      begin
         wait_r <= 1'b1;
         if ((avs_req.read || avs_req.write) && wait_r)
         begin
            wait_r  <= 1'b0;
            rdata_r <= 32'h0;
            if (avs_req.read && avs_req.address == `CBDL_REG_CTRL)
               rdata_r <= {24'h0, wd_to_r};
            else if (avs_req.read &&
                     avs_req.address == `CBDL_REG_STAT)
               rdata_r <= stat;
         end
         if (avs_req.write && !wait_r &&
             avs_req.address == `CBDL_REG_CTRL)
            wd_to_r <= avs_req.writedata[7:0];
      end
   end
   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;

   // Checks on the shared logic
   property p_test_mid;
      (mode_f == CBDL_MODE_MID) |-> (test && !fb_int);
   endproperty
   a_test_mid: assert property (p_test_mid)
      else $error("middle mode level not in test");
   property p_fb_low;
      test |-> !fb_rise;
   endproperty
   a_fb_low: assert property (p_fb_low)
      else $error("feedback edge seen in test mode");
   property p_err_drop;
      (lock_r && ph_err_r && err_cnt_r == ERR_LAST) |=> !lock_r;
   endproperty
   a_err_drop: assert property (p_err_drop)
      else $error("lock kept after error run");
   property p_lock_rise;
      $rose(lock_r) |-> $past(good_cnt_r) == GOOD_LAST &&
                        $past(ph_ok_r);
   endproperty
   a_lock_rise: assert property (p_lock_rise)
      else $error("lock rose without clean run");
   property p_wd_drop;
      wd_exp |=> !lock_r;
   endproperty
   a_wd_drop: assert property (p_wd_drop)
      else $error("watchdog expiry kept lock");
   property p_trst_hold;
      (tr_r == TR_COUNT && test && bank_b_off_input && ref_rise &&
       tr_cnt_r == TRST_LAST) |=> sm_rst ##1 (!oe_v[0] && !oe_v[1]);
   endproperty
   a_trst_hold: assert property (p_trst_hold)
      else $error("test reset not entered on fifth edge");
   property p_trst_exit;
      (sm_rst && !bank_b_off_input) |=> (tr_r == TR_IDLE);
   endproperty
   a_trst_exit: assert property (p_trst_exit)
      else $error("test reset not released");

   c_lock: cover property ($rose(lock_r));
   c_unlock: cover property ($fell(lock_r));
   c_hold: cover property ($rose(sm_rst));
endmodule

/* dv/cbdl_clk_src.sv */
// Reference, feedback and PLL clock source facing the block
`timescale 1ns/100ps
module cbdl_clk_src
(
   // System
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Controls from the bench
   input  wire logic [2:0] fb_lag,
   input  wire logic       fb_run,
   // Clock pins
   output logic            ref_in,
   output logic            feedback_in,
   output logic            pll_clk_in
);
   logic [3:0] div_r;
   logic [7:0] dly_r;

   // Twelve-cycle clock, slow enough for the pin filter
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_r <= 4'h0;
         dly_r <= 8'h00;
      end
      else
      begin
         div_r <= (div_r == 4'hB) ? 4'h0 : div_r + 4'h1;
         dly_r <= {dly_r[6:0], div_r < 4'h6};
      end
   end

   // Reference never stops, so the lock flag stays meaningful
   assign ref_in      = dly_r[0];
   assign pll_clk_in  = dly_r[0];
   // Stopped feedback rests low; lag makes phase errors
   assign feedback_in = fb_run & dly_r[fb_lag];
endmodule

/* dv/testbench.sv */
// Self-checking bench for the clock bank control block
`timescale 1ns/100ps
module testbench;
   import cbdl_pkg::*;
   localparam int LIMIT = 20000;
   logic          clock;
   logic          rst_n;
   logic [1:0]    mode_level;
   logic [1:0]    bank_off_inputs;
   logic [2:0]    fb_lag;
   logic          fb_run;
   logic          ref_in;
   logic          feedback_in;
   logic          pll_clk_in;
   logic [3:0]    bank_a_outputs;
   logic [3:0]    bank_a_oe;
   logic [5:0]    bank_b_outputs;
   logic [5:0]    bank_b_oe;
   logic          lock_out;
   cbdl_avs_req_t avs_req;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [31:0]   rnd_state;
   logic [31:0]   rd;
   logic          a_q = 1'b0;
   logic          b_q = 1'b0;
   int            mismatches = 0;
   int            tests_run = 0;
   int            cycles = 0;
   int            rise_a = 0;
   int            rise_b = 0;
   int            run_a = 0;
   int            short_a = 0;

   cbdl_top u_cbdl_top
   (
      .clock           (clock),
      .rst_n           (rst_n),
      .mode_level      (mode_level),
      .bank_off_inputs (bank_off_inputs),
      .ref_in          (ref_in),
      .feedback_in     (feedback_in),
      .pll_clk_in      (pll_clk_in),
      .bank_a_outputs  (bank_a_outputs),
      .bank_a_oe       (bank_a_oe),
      .bank_b_outputs  (bank_b_outputs),
      .bank_b_oe       (bank_b_oe),
      .lock_out        (lock_out),
      .avs_req         (avs_req),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest)
   );

   cbdl_clk_src u_cbdl_clk_src
   (
      .clock       (clock),
      .rst_n       (rst_n),
      .fb_lag      (fb_lag),
      .fb_run      (fb_run),
      .ref_in      (ref_in),
      .feedback_in (feedback_in),
      .pll_clk_in  (pll_clk_in)
   );

   // Free-running 125 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Expected status word from its fields
   function automatic logic [31:0] stat_exp(input logic lk, input logic ts,
      input logic hd, input cbdl_park_t pa, input cbdl_park_t pb);
      return {25'h0, pb, pa, hd, ts, lk};
   endfunction

   function automatic bit cond(input int k);
      case (k)
         0: return lock_out === 1'b1;
         1: return lock_out === 1'b0;
         2: return {bank_a_oe, bank_b_oe} === 10'h000;
         default: return {bank_a_oe, bank_b_oe} === 10'h3FF;
      endcase
   endfunction

   task automatic end_sim();
      $display("Counts: %0d mismatches, %0d checks", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
      input string msg);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // Bounded wait for a settled condition
   task automatic wait_for(input int k, input int lim);
      int n;
      n = 0;
      while (!cond(k) && n < lim)
      begin
         @(posedge clock);
         n++;
      end
      check(cond(k), 1'b1, "wait");
   endtask

   // One Avalon transfer; held until waitrequest is seen low
   // A stuck slave is caught by the hang guard, not here
   task automatic bus(input logic wr, input logic adr,
      input logic [31:0] wd, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clock);
      avs_req <= '{read: !wr, write: wr, address: adr, writedata: wd};
      do
      begin
         @(posedge clock);
         n++;
      end
      while (avs_waitrequest !== 1'b0);
      check(n, 2, "bus");
      q = avs_readdata;
      avs_req <= '0;
   endtask

   task automatic zero();
      rise_a = 0;
      rise_b = 0;
      short_a = 0;
   endtask

   // Edge watch on one pin of each bank, pulse-width watch on bank A only
   always @(posedge clock)
   begin
      if (bank_a_outputs[0] && !a_q)
         rise_a++;
      if (bank_b_outputs[0] && !b_q)
         rise_b++;
      if (!bank_a_outputs[0] && a_q && run_a < 6)
         short_a++;
      run_a = bank_a_outputs[0] ? run_a + 1 : 0;
      a_q = bank_a_outputs[0];
      b_q = bank_b_outputs[0];
   end

   // Hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         mismatches++;
         $display("MISMATCH %0t timeout", $time);
         end_sim();
      end
   end

   // Main sequence
   initial
   begin
      rst_n = 1'b0;
      mode_level = 2'h0;
      bank_off_inputs = 2'h0;
      fb_lag = 3'h0;
      fb_run = 1'b0;
      avs_req = '0;
      rnd_state = 32'h5982;
      repeat (5) @(posedge clock);
      check({bank_a_oe, bank_b_oe, bank_a_outputs, bank_b_outputs, lock_out},
         {10'h3FF, 11'h000}, "reset");
      rst_n <= 1'b1;
      // Register defaults, random writes, read-only status
      bus(1'b0, 1'b0, 32'h0, rd);
      check(rd, 32'h10, "ctrl reset");
      bus(1'b1, 1'b1, 32'hFF, rd);
      bus(1'b0, 1'b1, 32'h0, rd);
      check(rd, stat_exp(1'b0, 1'b0, 1'b0, PK_RUN, PK_RUN), "stat");
      repeat (3)
      begin
         rnd_state = xs(rnd_state);
         bus(1'b1, 1'b0, rnd_state, rd);
         bus(1'b0, 1'b0, 32'h0, rd);
         check(rd, {24'h0, rnd_state[7:0]}, "ctrl");
      end
      bus(1'b1, 1'b0, 32'h4, rd);
      // Both banks run while enabled
      zero();
      repeat (60) @(posedge clock);
      check(rise_a >= 4 && rise_b >= 4, 1'b1, "run");
      // Park bank A: filter plus six output cycles
      bank_off_inputs <= 2'h1;
      repeat (77) @(posedge clock);
      rise_a = 0;
      rise_b = 0;
      repeat (36) @(posedge clock);
      check(rise_a, 0, "park");
      check(rise_b >= 3, 1'b1, "bank b runs");
      check(short_a, 0, "short pulse");
      check(bank_a_oe, 4'hF, "park oe");
      bus(1'b0, 1'b1, 32'h0, rd);
      check(rd, stat_exp(1'b0, 1'b0, 1'b0, PK_PARK, PK_RUN), "pk");
      bank_off_inputs <= 2'h0;
      repeat (12) @(posedge clock);
      // Float bank B at once; mode settles first as a static pin
      mode_level <= 2'h2;
      repeat (10) @(posedge clock);
      bank_off_inputs <= 2'h2;
      #1;
      check({bank_b_oe, bank_a_oe}, {6'h00, 4'hF}, "float");
      @(posedge clock);
      bank_off_inputs <= 2'h0;
      mode_level <= 2'h0;
      // Lock needs 32 clean feedback cycles
      fb_run <= 1'b1;
      repeat (360) @(posedge clock);
      check(lock_out, 1'b0, "early lock");
      wait_for(0, 100);
      // Lock held past the watchdog span while feedback runs
      repeat (800) @(posedge clock);
      check(lock_out, 1'b1, "held");
      // Late feedback gives phase errors
      fb_lag <= 3'h4;
      repeat (24) @(posedge clock);
      check(lock_out, 1'b1, "early drop");
      wait_for(1, 60);
      // An error in mid count restarts it
      fb_lag <= 3'h0;
      repeat (240) @(posedge clock);
      fb_lag <= 3'h4;
      repeat (24) @(posedge clock);
      fb_lag <= 3'h0;
      repeat (360) @(posedge clock);
      check(lock_out, 1'b0, "restart");
      wait_for(0, 100);
      // Stopped feedback, watchdog of four ticks
      fb_run <= 1'b0;
      repeat (540) @(posedge clock);
      check(lock_out, 1'b1, "wd early");
      wait_for(1, 300);
      fb_run <= 1'b1;
      wait_for(0, 500);
      // Every mode code; pin moved only between phases
      for (int m = 0; m < 4; m++)
      begin
         mode_level <= m[1:0];
         repeat (10) @(posedge clock);
         bus(1'b0, 1'b1, 32'h0, rd);
         check(rd[1], m[0], "mode");
      end
      // Test mode ignores bank A disable, reference drives banks
      mode_level <= 2'h1;
      bank_off_inputs <= 2'h1;
      zero();
      repeat (48) @(posedge clock);
      check(rise_a >= 3, 1'b1, "test clk");
      check(bank_a_oe, 4'hF, "test oe");
      bus(1'b0, 1'b1, 32'h0, rd);
      check(rd[4:3], PK_RUN, "test park");
      wait_for(1, 1000);
      // Test reset after five reference rises
      bank_off_inputs <= 2'h3;
      repeat (30) @(posedge clock);
      check({bank_a_oe, bank_b_oe}, 0, "trst oe");
      bus(1'b0, 1'b1, 32'h0, rd);
      check(rd[2], 1'b0, "trst early");
      wait_for(2, 80);
      repeat (50) @(posedge clock);
      bus(1'b0, 1'b1, 32'h0, rd);
      check(rd, stat_exp(1'b0, 1'b1, 1'b1, PK_RUN, PK_RUN), "hold");
      check({bank_a_oe, bank_b_oe, bank_a_outputs, bank_b_outputs}, 0,
         "hold pins");
      bank_off_inputs <= 2'h0;
      wait_for(3, 20);
      end_sim();
   end
endmodule
